// *** rtl/wgt_pkg.sv ***
// constants and types shared by the windowed guard timer
//
// What this block does
// - unfed timeout while enabled resets the chip
// - windowed mode: feeds outside window are errors
// - warning interrupt at programmable count before timeout
// - 24-bit counter advances every four guard ticks
// - timeout from 256x4 to 2^24x4 ticks
// - enable cannot be cleared by software writes
// - bad feed sequence gives immediate guard event
// - protected reload writable only after warning point
// - readable flag: last reset caused by guard
// - counter runs from the 500 kHz oscillator
// - optionally keeps counting in deep sleep, power down
// - guard reset or interrupt wakes sleeping chip
// - mode, warning and window locked once enabled until reset
package wgt_pkg;

  // counter and bus widths
  localparam int unsigned CNT_W  = 24;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_RELOAD = 8'h04;
  localparam logic [7:0] OFS_FEED   = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0c;
  localparam logic [7:0] OFS_WARN   = 8'h10;
  localparam logic [7:0] OFS_WINDOW = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MASK   = 8'h1c;

  // mode register fields
  localparam int unsigned MODE_EN   = 0;
  localparam int unsigned MODE_RST  = 1;
  localparam int unsigned MODE_WIN  = 2;
  localparam int unsigned MODE_PROT = 3;
  localparam int unsigned MODE_SLP  = 4;
  localparam int unsigned MODE_W    = 5;

  // status and mask fields
  localparam int unsigned ST_TMO  = 0;
  localparam int unsigned ST_WARN = 1;
  localparam int unsigned ST_FERR = 2;
  localparam int unsigned ST_WDRST = 3;
  localparam int unsigned ST_W    = 4;

  // reset values
  localparam logic [4:0]  RST_MODE   = 5'h00;
  localparam logic [23:0] RST_RELOAD = 24'hffffff;
  localparam logic [23:0] RST_WARN   = 24'h000000;
  localparam logic [23:0] RST_WINDOW = 24'hffffff;
  localparam logic [3:0]  RST_MASK   = 4'h0;

  // smallest reload: 256 counts of four ticks
  localparam logic [23:0] RELOAD_MIN = 24'h0000ff;

  // feed keys, written back to back
  localparam logic [31:0] FEED_KEY1 = 32'h000000aa;
  localparam logic [31:0] FEED_KEY2 = 32'h00000055;

  // fixed prescaler: one count per four oscillator ticks
  localparam logic [1:0] PRE_LAST = 2'h3;

  // feed sequence tracker
  typedef enum logic {
    WGT_FEED_IDLE,
    WGT_FEED_ARMED
  } wgt_feed_e;

endpackage

// *** rtl/wgt_prescale.sv ***
// oscillator edge detector and fixed divide-by-four prescaler
`timescale 1ns/100ps
module wgt_prescale (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // oscillator level and run gate
  input  wire logic guard_tick_clock,
  input  wire logic run,
  // one-cycle count pulse
  output logic      tick
);

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [1:0] div;
    logic       tick;
  } wgt_pre_s;

  wgt_pre_s s_r;
  wgt_pre_s s_nxt;
  logic     osc_edge;

  // rising edge seen on the synchronised level only
  always_comb begin
    s_nxt       = s_r;
    osc_edge    = s_r.sync2 & ~s_r.prev;
    s_nxt.sync1 = guard_tick_clock;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev  = s_r.sync2;
    s_nxt.tick  = 1'b0;
    if (!run) begin
      s_nxt.div = 2'h0; // restart the quarter whenever counting is stopped: disabled, or asleep without MODE_SLP
    end else if (osc_edge) begin
      s_nxt.div = s_r.div + 2'h1;
      if (s_r.div == wgt_pkg::PRE_LAST) begin
        s_nxt.tick = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

  // two oscillator edges are at least two clocks apart
  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!rst_b)
    tick |=> !tick [*7])
    else $error("prescaler ticks closer than four oscillator edges");

endmodule

// *** rtl/wgt_top.sv ***
// windowed guard timer: register port, counter, feed check, events
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module windowed_guard_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // low-power oscillator level
  input  wire logic        guard_tick_clock,
  // chip state and reset history
  input  wire logic        sleep_mode,
  input  wire logic        reset_cause_wdt,
  // outputs to the system
  output logic             irq,
  output logic             chip_reset_req,
  output logic             wake_req
);

  typedef struct packed {
    logic [4:0]          mode;
    logic [23:0]         reload;
    logic [23:0]         warn;
    logic [23:0]         window;
    logic [23:0]         count;
    logic [3:0]          status;
    logic [3:0]          mask;
    wgt_pkg::wgt_feed_e  feed;
    logic [31:0]         rdata;
    logic                irq;
    logic                chip_rst;
    logic                wake;
    logic                cause_done;
  } wgt_state_s;

  wgt_state_s s_r;
  wgt_state_s s_nxt;

  logic enabled;
  logic run;
  logic tick;
  logic is_feed;
  logic too_early;
  logic locked_reload;

  // decodes shared by the next-state logic and the checks
  assign enabled       = s_r.mode[wgt_pkg::MODE_EN];
  assign is_feed       = reg_wr && (reg_addr == wgt_pkg::OFS_FEED);
  assign too_early     = s_r.mode[wgt_pkg::MODE_WIN] && (s_r.count > s_r.window);
  assign locked_reload = enabled && s_r.mode[wgt_pkg::MODE_PROT]
                         && (s_r.count > s_r.warn);

  // counting stops in sleep unless software asked otherwise
  assign run = enabled && (!sleep_mode || s_r.mode[wgt_pkg::MODE_SLP]);

  // oscillator edges divided by four into count pulses
  wgt_prescale u_pre (
    .clk              (clk),
    .rst_b            (rst_b),
    .guard_tick_clock (guard_tick_clock),
    .run              (run),
    .tick             (tick)
  );

  // next state of the whole block
  always_comb begin
    logic       ev_tmo;
    logic       ev_warn;
    logic       ev_ferr;
    logic       ev_cause;
    logic       good_feed;
    logic       bad_feed;
    logic [3:0] set_bits;
    logic [3:0] clr_bits;
    logic [23:0] dec;
    ev_tmo    = 1'b0;
    ev_warn   = 1'b0;
    ev_ferr   = 1'b0;
    ev_cause  = 1'b0;
    good_feed = 1'b0;
    bad_feed  = 1'b0;
    set_bits  = 4'h0;
    clr_bits  = 4'h0;
    dec       = s_r.count - 24'h000001;
    s_nxt     = s_r;

    // reset cause latched once, just after release
    // a later change of the cause input is ignored until the next reset
    if (!s_r.cause_done) begin
      s_nxt.cause_done = 1'b1;
      ev_cause         = reset_cause_wdt;
    end

    // down counter, one step per prescaled pulse
    // a timeout reloads and keeps counting, so warnings go on after it
    if (run && tick) begin
      if (s_r.count == 24'h000000) begin
        ev_tmo      = 1'b1;
        s_nxt.count = s_r.reload;
      end else begin
        s_nxt.count = dec;
        if (dec == s_r.warn) begin
          ev_warn = 1'b1;
        end
      end
    end

    // feed sequence: key one, then key two on the very next access
    // any access in between breaks the pair, a read as much as a write
    unique case (s_r.feed)
      wgt_pkg::WGT_FEED_IDLE: begin
        if (is_feed) begin
          if (reg_wdata == wgt_pkg::FEED_KEY1) begin
            s_nxt.feed = wgt_pkg::WGT_FEED_ARMED;
          end else begin
            bad_feed = 1'b1;
          end
        end
      end
      wgt_pkg::WGT_FEED_ARMED: begin
        if (reg_wr || reg_rd) begin
          s_nxt.feed = wgt_pkg::WGT_FEED_IDLE;
          if (is_feed && (reg_wdata == wgt_pkg::FEED_KEY2)) begin
            good_feed = 1'b1;
          end else begin
            bad_feed = 1'b1;
          end
        end
      end
    endcase

    // a feed in the closed part of the window counts as bad
    // the lower edge of the window is the timeout itself
    if (good_feed && enabled && too_early) begin
      good_feed = 1'b0;
      bad_feed  = 1'b1;
    end

    // valid feed restarts the count from the reload value
    if (good_feed && enabled) begin
      s_nxt.count = s_r.reload;
    end

    // bad feeds only matter once the timer is enabled, in sleep too
    if (bad_feed && enabled) begin
      ev_ferr = 1'b1;
    end

    // mode, warning and window frozen after enable; no write clears enable
    if (reg_wr && !enabled) begin
      unique case (reg_addr)
        wgt_pkg::OFS_MODE: begin
          s_nxt.mode = reg_wdata[wgt_pkg::MODE_W-1:0];
          if (reg_wdata[wgt_pkg::MODE_EN]) begin
            s_nxt.count = s_r.reload;
          end
        end
        wgt_pkg::OFS_WARN: begin
          s_nxt.warn = reg_wdata[23:0];
        end
        wgt_pkg::OFS_WINDOW: begin
          s_nxt.window = reg_wdata[23:0];
        end
        default: begin
        end
      endcase
    end

    // reload: protected writes wait for the warning point
    // short values are raised to the floor rather than dropped, so
    // software can never arm a timeout below the smallest one
    if (reg_wr && (reg_addr == wgt_pkg::OFS_RELOAD) && !locked_reload) begin
      if (reg_wdata[23:0] < wgt_pkg::RELOAD_MIN) begin
        s_nxt.reload = wgt_pkg::RELOAD_MIN;
      end else begin
        s_nxt.reload = reg_wdata[23:0];
      end
    end

    // interrupt mask stays writable so software can quiet warnings
    if (reg_wr && (reg_addr == wgt_pkg::OFS_MASK)) begin
      s_nxt.mask = reg_wdata[wgt_pkg::ST_W-1:0];
    end

    // sticky status: write one to clear, a new event wins
    // no clear can hide an event that lands in the same cycle
    if (reg_wr && (reg_addr == wgt_pkg::OFS_STATUS)) begin
      clr_bits = reg_wdata[wgt_pkg::ST_W-1:0];
    end
    set_bits[wgt_pkg::ST_TMO]   = ev_tmo;
    set_bits[wgt_pkg::ST_WARN]  = ev_warn;
    set_bits[wgt_pkg::ST_FERR]  = ev_ferr;
    set_bits[wgt_pkg::ST_WDRST] = ev_cause;
    s_nxt.status = (s_r.status & ~clr_bits) | set_bits;

    // chip reset request held until the chip reset returns
    if ((ev_tmo || ev_ferr) && s_r.mode[wgt_pkg::MODE_RST]) begin
      s_nxt.chip_rst = 1'b1;
    end

    // level interrupt from unmasked sticky bits
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);

    // either request pulls the chip out of low power
    s_nxt.wake = sleep_mode && (s_nxt.chip_rst || s_nxt.irq);

    // read data valid only in the cycle after the strobe
    s_nxt.rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        wgt_pkg::OFS_MODE:   s_nxt.rdata = {27'h0000000, s_r.mode};
        wgt_pkg::OFS_RELOAD: s_nxt.rdata = {8'h00, s_r.reload};
        wgt_pkg::OFS_COUNT:  s_nxt.rdata = {8'h00, s_r.count};
        wgt_pkg::OFS_WARN:   s_nxt.rdata = {8'h00, s_r.warn};
        wgt_pkg::OFS_WINDOW: s_nxt.rdata = {8'h00, s_r.window};
        wgt_pkg::OFS_STATUS: s_nxt.rdata = {28'h0000000, s_r.status};
        wgt_pkg::OFS_MASK:   s_nxt.rdata = {28'h0000000, s_r.mask};
        default:             s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // state register; only a chip reset returns the block to idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r.mode       <= wgt_pkg::RST_MODE;
      s_r.reload     <= wgt_pkg::RST_RELOAD;
      s_r.warn       <= wgt_pkg::RST_WARN;
      s_r.window     <= wgt_pkg::RST_WINDOW;
      s_r.count      <= wgt_pkg::RST_RELOAD;
      s_r.status     <= 4'h0;
      s_r.mask       <= wgt_pkg::RST_MASK;
      s_r.feed       <= wgt_pkg::WGT_FEED_IDLE;
      s_r.rdata      <= 32'h00000000;
      s_r.irq        <= 1'b0;
      s_r.chip_rst   <= 1'b0;
      s_r.wake       <= 1'b0;
      s_r.cause_done <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata      = s_r.rdata;
  assign irq            = s_r.irq;
  assign chip_reset_req = s_r.chip_rst;
  assign wake_req       = s_r.wake;

  // checks next to the logic they guard
  AST_ENABLE_STICKS: assert property (@(posedge clk) disable iff (!rst_b)
    enabled |=> enabled)
    else $error("enable dropped without reset");

  AST_TIMEOUT_RESET: assert property (@(posedge clk) disable iff (!rst_b)
    (run && tick && s_r.count == 24'h000000 && s_r.mode[wgt_pkg::MODE_RST])
    |=> chip_reset_req && s_r.status[wgt_pkg::ST_TMO])
    else $error("timeout did not request chip reset");

  AST_WINDOW_EARLY: assert property (@(posedge clk) disable iff (!rst_b)
    (enabled && too_early && s_r.feed == wgt_pkg::WGT_FEED_ARMED && is_feed)
    |=> s_r.status[wgt_pkg::ST_FERR]
        && (s_r.count == $past(s_r.count)
            || s_r.count == $past(s_r.count) - 24'h000001))
    else $error("early feed not flagged");

  AST_WARN_POINT: assert property (@(posedge clk) disable iff (!rst_b)
    (run && tick && s_r.count != 24'h000000 && s_r.count - 24'h000001 == s_r.warn)
    |=> s_r.status[wgt_pkg::ST_WARN])
    else $error("warning point missed");

  AST_RELOAD_FLOOR: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == wgt_pkg::OFS_RELOAD && !locked_reload
    |=> s_r.reload >= wgt_pkg::RELOAD_MIN)
    else $error("reload below smallest timeout");

  AST_BAD_FEED: assert property (@(posedge clk) disable iff (!rst_b)
    (enabled && s_r.mode[wgt_pkg::MODE_RST] && is_feed
     && s_r.feed == wgt_pkg::WGT_FEED_IDLE && reg_wdata != wgt_pkg::FEED_KEY1)
    |=> chip_reset_req)
    else $error("bad feed did not cause immediate event");

  AST_RELOAD_GUARD: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr && reg_addr == wgt_pkg::OFS_RELOAD && locked_reload)
    |=> $stable(s_r.reload))
    else $error("protected reload changed early");

  AST_CAUSE_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
    (!s_r.cause_done && reset_cause_wdt) |=> s_r.status[wgt_pkg::ST_WDRST])
    else $error("reset cause not recorded");

  AST_SLEEP_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    (enabled && sleep_mode && !s_r.mode[wgt_pkg::MODE_SLP] && !reg_wr && !reg_rd)
    |=> $stable(s_r.count))
    else $error("counter moved in sleep");

  AST_WAKE: assert property (@(posedge clk) disable iff (!rst_b)
    (sleep_mode && chip_reset_req) |=> wake_req)
    else $error("no wake on guard event");

  AST_CFG_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
    (enabled && reg_wr) |=> $stable(s_r.mode) && $stable(s_r.warn)
                             && $stable(s_r.window))
    else $error("configuration changed while locked");

  AST_GOOD_FEED: assert property (@(posedge clk) disable iff (!rst_b)
    (enabled && !too_early && s_r.feed == wgt_pkg::WGT_FEED_ARMED && is_feed
     && reg_wdata == wgt_pkg::FEED_KEY2) |=> s_r.count == $past(s_r.reload))
    else $error("valid feed did not reload counter");

  // outputs and read port
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
    irq == |(s_r.status & s_r.mask))
    else $error("interrupt level disagrees with status and mask");

  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside a read");

  AST_RESET_HELD: assert property (@(posedge clk) disable iff (!rst_b)
    chip_reset_req |=> chip_reset_req)
    else $error("chip reset request dropped");

  AST_WAKE_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
    (sleep_mode && irq && !reg_wr) |=> wake_req)
    else $error("no wake on interrupt");

  // counter steps, checked against the previous value
  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_b)
    (run && tick && s_r.count != 24'h000000 && !reg_wr)
    |=> s_r.count == $past(s_r.count) - 24'h000001)
    else $error("counter did not step down by one");

  AST_TIMEOUT_RELOAD: assert property (@(posedge clk) disable iff (!rst_b)
    (run && tick && s_r.count == 24'h000000 && !reg_wr)
    |=> s_r.count == $past(s_r.reload))
    else $error("timeout did not reload the counter");

  AST_COUNT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    (!run && !reg_wr) |=> $stable(s_r.count))
    else $error("counter moved while stopped");

endmodule

// *** test/wgt_tb.sv ***
// self-checking bench for the windowed guard timer
`timescale 1ns/100ps
module tb;
  // clock, reset and register port
  logic        clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  // oscillator, chip state and outputs
  logic        guard_tick_clock;
  logic        sleep_mode;
  logic        reset_cause_wdt;
  logic        irq;
  logic        chip_reset_req;
  logic        wake_req;
  // bookkeeping
  int          fails;
  int          total_checks;
  logic [31:0] rd_val;

  windowed_guard_timer DUT (
    .clk              (clk),
    .rst_b            (rst_b),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .guard_tick_clock (guard_tick_clock),
    .sleep_mode       (sleep_mode),
    .reset_cause_wdt  (reset_cause_wdt),
    .irq              (irq),
    .chip_reset_req   (chip_reset_req),
    .wake_req         (wake_req)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // compare with case equality so unknowns never match
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // reset held for 8 cycles
  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    rd_val = reg_rdata;
    check(name, exp, rd_val);
  endtask

  // both keys back to back, strobe held across them
  task automatic feed();
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= wgt_pkg::OFS_FEED;
    reg_wdata <= wgt_pkg::FEED_KEY1;
    @(posedge clk);
    reg_wdata <= wgt_pkg::FEED_KEY2;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // n oscillator rising edges, three clocks a phase, then settle past sync latency
  task automatic osc(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk);
      guard_tick_clock <= 1'b1;
      repeat (3) @(posedge clk);
      guard_tick_clock <= 1'b0;
    end
    repeat (6) @(posedge clk);
    #1;
  endtask

  // let registered flags land
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  // reset values, reset flag, unmapped place, mask and clear
  task automatic t_reset();
    @(posedge clk);
    reset_cause_wdt <= 1'b1;
    do_reset();
    rd_chk("mode", wgt_pkg::OFS_MODE, 32'h00000000);
    rd_chk("reload", wgt_pkg::OFS_RELOAD, {8'h00, wgt_pkg::RST_RELOAD});
    rd_chk("count", wgt_pkg::OFS_COUNT, 32'h00ffffff);
    rd_chk("warn", wgt_pkg::OFS_WARN, {8'h00, wgt_pkg::RST_WARN});
    rd_chk("window", wgt_pkg::OFS_WINDOW, {8'h00, wgt_pkg::RST_WINDOW});
    rd_chk("status", wgt_pkg::OFS_STATUS, 32'h00000008);
    wr(8'h40, 32'hffffffff);
    rd_chk("unmapped", 8'h40, 32'h00000000);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(wgt_pkg::OFS_MASK, 32'h00000008);
    settle();
    check("irq unmasked", 32'h1, {31'h0, irq});
    wr(wgt_pkg::OFS_STATUS, 32'h00000008);
    settle();
    check("irq cleared", 32'h0, {31'h0, irq});
    rd_chk("status clr", wgt_pkg::OFS_STATUS, 32'h00000000);
    wr(wgt_pkg::OFS_RELOAD, 32'h00000010);
    rd_chk("reload min", wgt_pkg::OFS_RELOAD, 32'h000000ff);
    @(posedge clk);
    reset_cause_wdt <= 1'b0;
  endtask

  // good feed reloads, broken and wrong keys flag a bad feed
  task automatic t_feed();
    do_reset();
    wr(wgt_pkg::OFS_RELOAD, 32'h00000300);
    wr(wgt_pkg::OFS_MODE, 32'h00000001);
    osc(8);
    rd_chk("count run", wgt_pkg::OFS_COUNT, 32'h000002fe);
    feed();
    rd_chk("count fed", wgt_pkg::OFS_COUNT, 32'h00000300);
    rd_chk("status fed", wgt_pkg::OFS_STATUS, 32'h00000000);
    wr(wgt_pkg::OFS_FEED, wgt_pkg::FEED_KEY1);
    rd_chk("split read", wgt_pkg::OFS_STATUS, 32'h00000000);
    rd_chk("split feed", wgt_pkg::OFS_STATUS, 32'h00000004);
    check("no reset without mode", 32'h0, {31'h0, chip_reset_req});
    wr(wgt_pkg::OFS_STATUS, 32'h00000004);
    wr(wgt_pkg::OFS_FEED, 32'h00000012);
    rd_chk("wrong key", wgt_pkg::OFS_STATUS, 32'h00000004);
  endtask

  // feed above and inside the window
  task automatic t_window();
    for (int i = 0; i < 2; i++) begin
      do_reset();
      wr(wgt_pkg::OFS_RELOAD, 32'h00000200);
      wr(wgt_pkg::OFS_WINDOW, (i == 1) ? 32'h00000200 : 32'h00000100);
      wr(wgt_pkg::OFS_MODE, 32'h00000007);
      feed();
      settle();
      check("window reset", (i == 1) ? 32'h0 : 32'h1, {31'h0, chip_reset_req});
      rd_chk("window status", wgt_pkg::OFS_STATUS, (i == 1) ? 32'h0 : 32'h4);
      wr(wgt_pkg::OFS_FEED, 32'h00000012);
      settle();
      check("bad key reset", 32'h1, {31'h0, chip_reset_req});
      rd_chk("bad key status", wgt_pkg::OFS_STATUS, 32'h00000004);
    end
  endtask

  // counting goes on through sleep when software asks for it
  task automatic t_sleep_run();
    do_reset();
    wr(wgt_pkg::OFS_RELOAD, 32'h00000100);
    wr(wgt_pkg::OFS_MODE, 32'h00000011);
    @(posedge clk);
    sleep_mode <= 1'b1;
    osc(4);
    rd_chk("count sleep run", wgt_pkg::OFS_COUNT, 32'h000000ff);
    @(posedge clk);
    sleep_mode <= 1'b0;
  endtask

  // prescale, warning, protection, lock, sleep, timeout and wake
  task automatic t_count();
    do_reset();
    wr(wgt_pkg::OFS_RELOAD, 32'h00000100);
    wr(wgt_pkg::OFS_WARN, 32'h000000fc);
    wr(wgt_pkg::OFS_MASK, 32'h0000000f);
    wr(wgt_pkg::OFS_MODE, 32'h0000000b);
    osc(3);
    rd_chk("count 3 edges", wgt_pkg::OFS_COUNT, 32'h00000100);
    osc(1);
    rd_chk("count 4 edges", wgt_pkg::OFS_COUNT, 32'h000000ff);
    wr(wgt_pkg::OFS_RELOAD, 32'h000001ff);
    rd_chk("reload guarded", wgt_pkg::OFS_RELOAD, 32'h00000100);
    osc(12);
    rd_chk("warn status", wgt_pkg::OFS_STATUS, 32'h00000002);
    check("warn irq", 32'h1, {31'h0, irq});
    wr(wgt_pkg::OFS_RELOAD, 32'h000001ff);
    rd_chk("reload open", wgt_pkg::OFS_RELOAD, 32'h000001ff);
    wr(wgt_pkg::OFS_MODE, 32'h00000000);
    rd_chk("mode locked", wgt_pkg::OFS_MODE, 32'h0000000b);
    wr(wgt_pkg::OFS_WARN, 32'h00000000);
    rd_chk("warn locked", wgt_pkg::OFS_WARN, 32'h000000fc);
    @(posedge clk);
    sleep_mode <= 1'b1;
    osc(8);
    check("wake on irq", 32'h1, {31'h0, wake_req});
    rd_chk("count slept", wgt_pkg::OFS_COUNT, 32'h000000fc);
    @(posedge clk);
    sleep_mode <= 1'b0;
    osc(1011);
    check("no early reset", 32'h0, {31'h0, chip_reset_req});
    osc(1);
    check("timeout reset", 32'h1, {31'h0, chip_reset_req});
    rd_chk("count reload", wgt_pkg::OFS_COUNT, 32'h000001ff);
    rd_chk("timeout status", wgt_pkg::OFS_STATUS, 32'h00000003);
    wr(wgt_pkg::OFS_STATUS, 32'h00000003);
    @(posedge clk);
    sleep_mode <= 1'b1;
    settle();
    check("wake on reset", 32'h1, {31'h0, wake_req});
    @(posedge clk);
    sleep_mode <= 1'b0;
  endtask

  // cut a hang short
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    complete_run();
  end

  // main sequence
  initial begin
    fails = 0;
    total_checks = 0;
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    guard_tick_clock = 1'b0;
    sleep_mode = 1'b0;
    reset_cause_wdt = 1'b0;
    t_reset();
    t_feed();
    t_window();
    t_sleep_run();
    t_count();
    complete_run();
  end
endmodule
